// ===== wsl_top.sv
// wsl_top: wake enable group 5, reserved 0F, two SMI status registers and their gating
`default_nettype none
module wsl_top
	import wsl_pkg::*;
(
	input wire logic clk_sys_in, // system clock, 100 MHz
	input wire logic rst_in, // main-power/hard/soft reset, sync high
	input wire logic rst_standby_in, // standby-power reset, sync high
	input wire wsl_pkg::wsl_bus_req_t bus_in, // register strobe, address, data
	output logic [7:0] rdata_out, // read data, cycle after read strobe
	input wire logic [7:0] gpio_g5_in, // group five pin wake status
	input wire wsl_pkg::wsl_periph_irq_t periph_irq_in, // peripheral requests
	input wire logic printer_acknowledge_n_in, // printer acknowledge pin
	input wire logic infrared_rx_primary_in, // primary ir receive pin
	input wire logic infrared_rx_secondary_in, // secondary ir receive pin
	output logic wake_event_out_n_out, // wake event, low active
	output logic wake_event_oe_n_out, // open-drain enable, low drives
	output logic group_sysmgmt_irq_n_out, // group smi, low active
	output logic irq_out // local interrupt, high active
);
	import wsl_pkg::*;

	// every pin input goes through three flops; second and third must agree
	logic [2:0] s_gp_reg [8];
	logic [2:0] s_gp_next [8];
	logic [7:0] gp_flt_reg, gp_flt_next;
	logic [2:0] s_ack_reg, s_ack_next;
	logic [2:0] s_irp_reg, s_irp_next;
	logic [2:0] s_irs_reg, s_irs_next;
	logic ack_flt_reg, ack_flt_next;
	logic ir_flt_reg, ir_flt_next;
	logic ir_prev_reg, ir_prev_next;

	logic [7:0] wake_en_reg, wake_en_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] smi_en1_reg, smi_en1_next;
	logic [7:0] smi_en2_reg, smi_en2_next;
	logic [7:0] irq_stat_reg, irq_stat_next;
	logic [7:0] irq_mask_reg, irq_mask_next;
	logic [7:0] sts1_reg, sts1_next;
	logic [7:0] sts2_reg, sts2_next;
	logic [7:0] rdata_reg, rdata_next;
	logic wake_reg, wake_next;
	logic smi_reg, smi_next;
	logic ir_edge, ir_sel;
	logic wr_ok, rd_ok;

	assign wr_ok = bus_in.wr;
	assign rd_ok = bus_in.rd;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_gp_sync
			always_comb begin
				s_gp_next[gi] = {s_gp_reg[gi][1:0], gpio_g5_in[gi]};
				gp_flt_next[gi] = (s_gp_reg[gi][1] == s_gp_reg[gi][2]) ?
					s_gp_reg[gi][2] : gp_flt_reg[gi];
			end
			always_ff @(posedge clk_sys_in) begin
				s_gp_reg[gi] <= s_gp_next[gi];
			end
		end
	endgenerate

	// ir selection picks the synchronized pin before filtering, so a mux flip onto a pin at another level looks like one edge
	always_comb begin
		s_ack_next = {s_ack_reg[1:0], printer_acknowledge_n_in};
		s_irp_next = {s_irp_reg[1:0], infrared_rx_primary_in};
		s_irs_next = {s_irs_reg[1:0], infrared_rx_secondary_in};
		ack_flt_next = (s_ack_reg[1] == s_ack_reg[2]) ? s_ack_reg[2] : ack_flt_reg;
		ir_sel = ctrl_reg[WSL_CTRL_IR_SEL] ? s_irs_reg[2] : s_irp_reg[2];
		if (ctrl_reg[WSL_CTRL_IR_SEL]) begin
			ir_flt_next = (s_irs_reg[1] == s_irs_reg[2]) ? ir_sel : ir_flt_reg;
		end else begin
			ir_flt_next = (s_irp_reg[1] == s_irp_reg[2]) ? ir_sel : ir_flt_reg;
		end
		ir_prev_next = ir_flt_reg;
	end
	assign ir_edge = ir_flt_reg ^ ir_prev_reg;

	always_ff @(posedge clk_sys_in) begin
		gp_flt_reg <= gp_flt_next;
		s_ack_reg <= s_ack_next;
		s_irp_reg <= s_irp_next;
		s_irs_reg <= s_irs_next;
		ack_flt_reg <= ack_flt_next;
		ir_flt_reg <= ir_flt_next;
		ir_prev_reg <= ir_prev_next;
	end

	// wake enable survives main-power reset; only standby reset clears it
	always_comb begin
		wake_en_next = wake_en_reg;
		if (rst_standby_in) begin
			wake_en_next = WSL_RST_WAKE_EN5;
		end else if (wr_ok && bus_in.addr == WSL_OFS_WAKE_EN5) begin
			wake_en_next = bus_in.wdata;
		end
	end

	always_comb begin
		ctrl_next = ctrl_reg;
		smi_en1_next = smi_en1_reg;
		smi_en2_next = smi_en2_reg;
		irq_mask_next = irq_mask_reg;
		if (rst_in || rst_standby_in) begin
			ctrl_next = WSL_RST_ZERO;
			smi_en1_next = WSL_RST_ZERO;
			smi_en2_next = WSL_RST_ZERO;
			irq_mask_next = WSL_RST_ZERO;
		end else if (wr_ok) begin
			unique case (bus_in.addr)
				WSL_OFS_CTRL: ctrl_next = bus_in.wdata & WSL_CTRL_USED;
				WSL_OFS_SMI_EN1: smi_en1_next = bus_in.wdata & WSL_STS1_USED;
				WSL_OFS_SMI_EN2: smi_en2_next = bus_in.wdata & WSL_STS2_USED;
				WSL_OFS_IRQ_MASK: irq_mask_next = bus_in.wdata & WSL_IRQ_USED;
				default: ;
			endcase
		end
	end

	// status 1 is a live view; host writes have no path into it
	always_comb begin
		sts1_next = WSL_RST_ZERO;
		sts1_next[WSL_BIT_SERB] = periph_irq_in.serial_b;
		sts1_next[WSL_BIT_SERA] = periph_irq_in.serial_a;
		sts1_next[WSL_BIT_FDC] = periph_irq_in.floppy;
		sts1_next[WSL_BIT_MIDI] = periph_irq_in.midi;
		sts1_next[WSL_BIT_PAR] = ctrl_reg[WSL_CTRL_PAR_ACT] ?
			ack_flt_reg : 1'b1;
		if (rst_in || rst_standby_in) begin
			sts1_next = WSL_RST_STS1;
		end
	end

	// ir flag: an edge in the cycle of the clearing read still sets it
	always_comb begin
		sts2_next = WSL_RST_ZERO;
		sts2_next[WSL_BIT_MOUSE] = periph_irq_in.mouse;
		sts2_next[WSL_BIT_KBD] = periph_irq_in.keyboard;
		sts2_next[WSL_BIT_P12] = periph_irq_in.kbc_p12;
		sts2_next[WSL_BIT_IR] = ir_edge ||
			(sts2_reg[WSL_BIT_IR] && !(rd_ok && bus_in.addr == WSL_OFS_STS2));
		if (rst_standby_in) begin
			sts2_next = WSL_RST_STS2;
		end
	end

	always_comb begin
		wake_next = |(wake_en_reg & gp_flt_reg) && ctrl_reg[WSL_CTRL_WAKE_EN];
		smi_next = |(sts1_reg & smi_en1_reg) || |(sts2_reg & smi_en2_reg);
		if (rst_in || rst_standby_in) begin
			wake_next = 1'b0;
			smi_next = 1'b0;
		end
	end

	// local interrupt: sticky bits, cleared by reading the status word
	always_comb begin
		irq_stat_next = irq_stat_reg;
		if (rd_ok && bus_in.addr == WSL_OFS_IRQ_STAT) begin
			irq_stat_next = WSL_RST_ZERO;
		end
		if (wake_next && !wake_reg) begin
			irq_stat_next[WSL_IRQ_WAKE] = 1'b1;
		end
		if (smi_next && !smi_reg) begin
			irq_stat_next[WSL_IRQ_SMI] = 1'b1;
		end
		if (ir_edge) begin
			irq_stat_next[WSL_IRQ_IR] = 1'b1;
		end
		if (rst_in || rst_standby_in) begin
			irq_stat_next = WSL_RST_ZERO;
		end
	end

	always_comb begin
		rdata_next = WSL_RST_ZERO;
		if (rd_ok) begin
			unique case (bus_in.addr)
				WSL_OFS_WAKE_EN5: rdata_next = wake_en_reg;
				WSL_OFS_RSVD_0F: rdata_next = WSL_RST_ZERO;
				WSL_OFS_STS1: rdata_next = sts1_reg & WSL_STS1_USED;
				WSL_OFS_STS2: rdata_next = sts2_reg & WSL_STS2_USED;
				WSL_OFS_CTRL: rdata_next = ctrl_reg;
				WSL_OFS_SMI_EN1: rdata_next = smi_en1_reg;
				WSL_OFS_SMI_EN2: rdata_next = smi_en2_reg;
				WSL_OFS_IRQ_STAT: rdata_next = irq_stat_reg;
				WSL_OFS_IRQ_MASK: rdata_next = irq_mask_reg;
				default: rdata_next = WSL_RST_ZERO;
			endcase
		end
		if (rst_in || rst_standby_in) begin
			rdata_next = WSL_RST_ZERO;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		wake_en_reg <= wake_en_next;
		ctrl_reg <= ctrl_next;
		smi_en1_reg <= smi_en1_next;
		smi_en2_reg <= smi_en2_next;
		irq_mask_reg <= irq_mask_next;
		irq_stat_reg <= irq_stat_next;
		sts1_reg <= sts1_next;
		sts2_reg <= sts2_next;
		wake_reg <= wake_next;
		smi_reg <= smi_next;
		rdata_reg <= rdata_next;
	end

	assign rdata_out = rdata_reg;
	assign wake_event_out_n_out = 1'b0;
	assign wake_event_oe_n_out = ~wake_reg;
	assign group_sysmgmt_irq_n_out = ~smi_reg;
	assign irq_out = |(irq_stat_reg & irq_mask_reg);

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in || rst_standby_in);

	sequence s_sts2_read;
		rd_ok && bus_in.addr == WSL_OFS_STS2 && !ir_edge;
	endsequence

	wake_gating_a: assert property (!wake_event_oe_n_out |->
		$past(ctrl_reg[WSL_CTRL_WAKE_EN]) && |$past(wake_en_reg & gp_flt_reg))
		else $error("wake driven without enable");
	wake_disabled_a: assert property ((wake_en_reg == 8'h00) |=> wake_event_oe_n_out)
		else $error("wake driven for disabled source");
	// main reset must not mask this check, so only standby reset disables it
	wake_keep_a: assert property (disable iff (rst_standby_in)
		rst_in && !wr_ok |=> $stable(wake_en_reg))
		else $error("wake enable lost on main reset");
	rsvd_zero_a: assert property (rd_ok && bus_in.addr == WSL_OFS_RSVD_0F |=> rdata_out == 8'h00)
		else $error("reserved offset read nonzero");
	par_idle_a: assert property (!ctrl_reg[WSL_CTRL_PAR_ACT] |=> sts1_reg[WSL_BIT_PAR])
		else $error("parallel flag not held high");
	par_track_a: assert property (ctrl_reg[WSL_CTRL_PAR_ACT] |=>
		sts1_reg[WSL_BIT_PAR] == $past(ack_flt_reg))
		else $error("parallel flag not tracking acknowledge");
	serial_view_a: assert property (1'b1 |=>
		sts1_reg[WSL_BIT_SERB] == $past(periph_irq_in.serial_b))
		else $error("serial b status not live");
	ir_clear_a: assert property (s_sts2_read |=> !sts2_reg[WSL_BIT_IR])
		else $error("ir flag not cleared by read");
	ir_set_a: assert property (ir_edge |=> sts2_reg[WSL_BIT_IR])
		else $error("ir edge not caught");
	smi_gate_a: assert property (!group_sysmgmt_irq_n_out |->
		|$past(sts1_reg & smi_en1_reg) || |$past(sts2_reg & smi_en2_reg))
		else $error("smi without enabled status");
	p12_view_a: assert property (1'b1 |=>
		sts2_reg[WSL_BIT_P12] == $past(periph_irq_in.kbc_p12))
		else $error("p12 status not live");

	sequence s_wake_write;
		wr_ok && bus_in.addr == WSL_OFS_WAKE_EN5;
	endsequence

	sequence s_wake_ready;
		ctrl_reg[WSL_CTRL_WAKE_EN] && |(wake_en_reg & gp_flt_reg);
	endsequence

	sequence s_smi_pending;
		|(sts1_reg & smi_en1_reg) || |(sts2_reg & smi_en2_reg);
	endsequence

	// wake enable register: loads on its own write only, reads back intact
	wake_en_load_a: assert property (s_wake_write |=>
		wake_en_reg == $past(bus_in.wdata))
		else $error("wake enable write lost");
	wake_en_hold_a: assert property (!(wr_ok && bus_in.addr == WSL_OFS_WAKE_EN5) |=>
		$stable(wake_en_reg))
		else $error("wake enable changed without write");
	wake_en_read_a: assert property (rd_ok && bus_in.addr == WSL_OFS_WAKE_EN5 |=>
		rdata_out == $past(wake_en_reg))
		else $error("wake enable read mismatch");

	// wake output follows the gate one cycle later
	wake_off_a: assert property (!ctrl_reg[WSL_CTRL_WAKE_EN] |=>
		wake_event_oe_n_out)
		else $error("wake driven with global enable off");
	wake_on_a: assert property (s_wake_ready |=> !wake_event_oe_n_out)
		else $error("wake not driven when gated on");
	gp_filter_a: assert property (s_gp_reg[0][1] != s_gp_reg[0][2] |=>
		$stable(gp_flt_reg[0]))
		else $error("pin filter passed a disagreeing sample");

	// status 1 is a live view, masked to its used bits
	sts1_read_a: assert property (rd_ok && bus_in.addr == WSL_OFS_STS1 |=>
		rdata_out == ($past(sts1_reg) & WSL_STS1_USED))
		else $error("status 1 read mismatch");
	sts1_rsvd_a: assert property ((sts1_reg & ~WSL_STS1_USED) == 8'h00)
		else $error("status 1 reserved bit set");
	sts1_nowrite_a: assert property (wr_ok && bus_in.addr == WSL_OFS_STS1 |=>
		sts1_reg[WSL_BIT_SERA] == $past(periph_irq_in.serial_a))
		else $error("status 1 changed by write");
	sera_view_a: assert property (1'b1 |=>
		sts1_reg[WSL_BIT_SERA] == $past(periph_irq_in.serial_a))
		else $error("serial a status not live");
	floppy_view_a: assert property (1'b1 |=>
		sts1_reg[WSL_BIT_FDC] == $past(periph_irq_in.floppy))
		else $error("floppy status not live");
	midi_view_a: assert property (1'b1 |=>
		sts1_reg[WSL_BIT_MIDI] == $past(periph_irq_in.midi))
		else $error("midi status not live");
	ack_filter_a: assert property (s_ack_reg[1] != s_ack_reg[2] |=>
		$stable(ack_flt_reg))
		else $error("acknowledge filter passed a disagreeing sample");

	// status 2: live bits plus the sticky ir flag
	mouse_view_a: assert property (1'b1 |=>
		sts2_reg[WSL_BIT_MOUSE] == $past(periph_irq_in.mouse))
		else $error("mouse status not live");
	kbd_view_a: assert property (1'b1 |=>
		sts2_reg[WSL_BIT_KBD] == $past(periph_irq_in.keyboard))
		else $error("keyboard status not live");
	kbd_keep_a: assert property (s_sts2_read |=>
		sts2_reg[WSL_BIT_KBD] == $past(periph_irq_in.keyboard))
		else $error("status 2 read disturbed keyboard bit");
	sts2_rsvd_a: assert property ((sts2_reg & ~WSL_STS2_USED) == 8'h00)
		else $error("status 2 reserved bit set");
	sts2_read_a: assert property (rd_ok && bus_in.addr == WSL_OFS_STS2 |=>
		rdata_out == ($past(sts2_reg) & WSL_STS2_USED))
		else $error("status 2 read mismatch");
	ir_hold_a: assert property (!ir_edge && sts2_reg[WSL_BIT_IR] &&
		!(rd_ok && bus_in.addr == WSL_OFS_STS2) |=> sts2_reg[WSL_BIT_IR])
		else $error("ir flag lost without read");
	ir_quiet_a: assert property (!ir_edge && !sts2_reg[WSL_BIT_IR] |=>
		!sts2_reg[WSL_BIT_IR])
		else $error("ir flag set without edge");
	irq_ir_set_a: assert property (ir_edge |=> irq_stat_reg[WSL_IRQ_IR])
		else $error("ir edge missed in interrupt status");

	// smi gating and masked enables
	smi_on_a: assert property (s_smi_pending |=> !group_sysmgmt_irq_n_out)
		else $error("smi not raised for enabled status");
	smi_off_a: assert property ((sts1_reg & smi_en1_reg) == 8'h00 &&
		(sts2_reg & smi_en2_reg) == 8'h00 |=> group_sysmgmt_irq_n_out)
		else $error("smi raised with nothing enabled");
	smi_en_mask_a: assert property ((smi_en1_reg & ~WSL_STS1_USED) == 8'h00)
		else $error("smi enable reserved bit set");
	ctrl_mask_a: assert property ((ctrl_reg & ~WSL_CTRL_USED) == 8'h00)
		else $error("control reserved bit set");
	unmapped_read_a: assert property (rd_ok && bus_in.addr > WSL_OFS_IRQ_MASK |=>
		rdata_out == 8'h00)
		else $error("unmapped read nonzero");
endmodule // wsl_top
`default_nettype wire

// ===== wsl_pkg.sv
// package: register map, field layout and reset values of the wake and status logic
`default_nettype none
package wsl_pkg;
	localparam logic [7:0] WSL_OFS_WAKE_EN5 = 8'h0E;
	localparam logic [7:0] WSL_OFS_RSVD_0F = 8'h0F;
	localparam logic [7:0] WSL_OFS_STS1 = 8'h10;
	localparam logic [7:0] WSL_OFS_STS2 = 8'h11;
	localparam logic [7:0] WSL_OFS_CTRL = 8'h18;
	localparam logic [7:0] WSL_OFS_SMI_EN1 = 8'h19;
	localparam logic [7:0] WSL_OFS_SMI_EN2 = 8'h1A;
	localparam logic [7:0] WSL_OFS_IRQ_STAT = 8'h1B;
	localparam logic [7:0] WSL_OFS_IRQ_MASK = 8'h1C;
	localparam logic [7:0] WSL_RST_WAKE_EN5 = 8'h00;
	localparam logic [7:0] WSL_RST_STS1 = 8'h02;
	localparam logic [7:0] WSL_RST_STS2 = 8'h00;
	localparam logic [7:0] WSL_RST_ZERO = 8'h00;
	localparam logic [7:0] WSL_STS1_USED = 8'h3E;
	localparam logic [7:0] WSL_STS2_USED = 8'h17;
	localparam int WSL_BIT_PAR = 1;
	localparam int WSL_BIT_SERB = 2;
	localparam int WSL_BIT_SERA = 3;
	localparam int WSL_BIT_FDC = 4;
	localparam int WSL_BIT_MIDI = 5;
	localparam int WSL_BIT_MOUSE = 0;
	localparam int WSL_BIT_KBD = 1;
	localparam int WSL_BIT_IR = 2;
	localparam int WSL_BIT_P12 = 4;
	localparam int WSL_CTRL_WAKE_EN = 0;
	localparam int WSL_CTRL_PAR_ACT = 1;
	localparam int WSL_CTRL_IR_SEL = 2;
	localparam int WSL_IRQ_WAKE = 0;
	localparam int WSL_IRQ_SMI = 1;
	localparam int WSL_IRQ_IR = 2;
	localparam logic [7:0] WSL_CTRL_USED = 8'h07;
	localparam logic [7:0] WSL_IRQ_USED = 8'h07;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} wsl_bus_req_t;

	typedef struct packed {
		logic midi;
		logic floppy;
		logic serial_a;
		logic serial_b;
		logic kbc_p12;
		logic keyboard;
		logic mouse;
	} wsl_periph_irq_t;
endpackage
`default_nettype wire

// ===== wsl_host_model.sv
// wsl_host_model: host side of the open-drain wake line and the group smi line
`default_nettype none
module wsl_host_model (
	input wire logic clk_sys_in, // system clock
	input wire logic wake_n_in, // wake data from the block
	input wire logic wake_oe_n_in, // low while the block drives
	input wire logic smi_n_in, // group smi from the block
	output logic wake_line_out, // resolved wake wire
	output logic smi_seen_out // smi level as the host samples it
);
	timeunit 1ns;
	timeprecision 1ns;
	// pull-up: a released line reads high, never the last driven value
	assign wake_line_out = wake_oe_n_in ? 1'b1 : wake_n_in;
	always_ff @(posedge clk_sys_in) begin
		smi_seen_out <= ~smi_n_in;
	end
endmodule // wsl_host_model
`default_nettype wire

// ===== test_wake_and_smi_status_logic.sv
// test_wake_and_smi_status_logic: register level test of the wake and status logic
`default_nettype none
module test_wake_and_smi_status_logic;
	timeunit 1ns;
	timeprecision 1ns;
	import wsl_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic rst_sb = 1'b1;
	wsl_bus_req_t bus = '0;
	wsl_periph_irq_t periph = '0;
	logic [7:0] gpio = 8'h00;
	logic ack_n = 1'b1;
	logic ir1 = 1'b0;
	logic ir2 = 1'b0;
	logic [7:0] rdata;
	logic [7:0] rd_v;
	logic wake_n;
	logic wake_oe_n;
	logic smi_n;
	logic irq;
	logic wake_line;
	logic smi_seen;
	int n_fail = 0;
	int n_tests = 0;
	logic [7:0] e1 [7] = '{8'h02, 8'h02, 8'h02, 8'h06, 8'h0A, 8'h12, 8'h22};
	logic [7:0] e2 [7] = '{8'h01, 8'h02, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
	always #5 clk_sys_in = ~clk_sys_in;
	wsl_top wsl_top_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .rst_standby_in(rst_sb),
		.bus_in(bus), .rdata_out(rdata), .gpio_g5_in(gpio), .periph_irq_in(periph),
		.printer_acknowledge_n_in(ack_n), .infrared_rx_primary_in(ir1),
		.infrared_rx_secondary_in(ir2), .wake_event_out_n_out(wake_n),
		.wake_event_oe_n_out(wake_oe_n), .group_sysmgmt_irq_n_out(smi_n), .irq_out(irq));
	wsl_host_model wsl_host_model_inst (.clk_sys_in(clk_sys_in), .wake_n_in(wake_n),
		.wake_oe_n_in(wake_oe_n), .smi_n_in(smi_n), .wake_line_out(wake_line),
		.smi_seen_out(smi_seen));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys_in);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_in);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys_in);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		check(d, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// a hang is cut short well inside the cycle budget
	initial begin
		#500us;
		n_fail++;
		final_report;
	end
	initial begin
		idle(8);
		rst_in <= 1'b0;
		rst_sb <= 1'b0;
		idle(6);
		rd(WSL_OFS_STS2, rd_v); // pin filters start unreset: drop a start-up edge
		rc(WSL_OFS_WAKE_EN5, 8'h00);
		foreach (e1[i]) wr(8'h0F + 8'(i % 3), 8'hFF);
		rc(WSL_OFS_RSVD_0F, 8'h00);
		rc(WSL_OFS_STS1, 8'h02);
		rc(WSL_OFS_STS2, 8'h00);
		rc(8'h30, 8'h00);
		$display("test reset and reserved done");
		for (int i = 0; i < 7; i++) begin
			periph <= wsl_periph_irq_t'(7'(1 << i));
			idle(3);
			rc(WSL_OFS_STS1, e1[i]);
			rc(WSL_OFS_STS2, e2[i]);
			idle(1);
		end
		periph <= 7'h7F;
		wr(WSL_OFS_STS1, 8'h00);
		rc(WSL_OFS_STS1, 8'h3E);
		idle(1);
		periph <= '0;
		idle(3);
		rc(WSL_OFS_STS1, 8'h02);
		$display("test status map done");
		idle(1);
		ack_n <= 1'b0;
		idle(6);
		rc(WSL_OFS_STS1, 8'h02);
		wr(WSL_OFS_CTRL, 8'h02);
		idle(6);
		rc(WSL_OFS_STS1, 8'h00);
		idle(1);
		ack_n <= 1'b1;
		idle(6);
		rc(WSL_OFS_STS1, 8'h02);
		$display("test parallel flag done");
		idle(1);
		periph <= 7'h01;
		ir1 <= 1'b1;
		idle(6);
		rc(WSL_OFS_STS2, 8'h05);
		rc(WSL_OFS_STS2, 8'h01);
		wr(WSL_OFS_CTRL, 8'h04);
		idle(6);
		rd(WSL_OFS_STS2, rd_v); // switching the selector may itself show an edge
		idle(1);
		ir1 <= 1'b0;
		idle(6);
		rc(WSL_OFS_STS2, 8'h01);
		idle(1);
		ir2 <= 1'b1;
		idle(6);
		rc(WSL_OFS_STS2, 8'h05);
		$display("test infrared done");
		wr(WSL_OFS_CTRL, 8'h01);
		for (int i = 0; i < 8; i++) begin
			wr(WSL_OFS_WAKE_EN5, 8'(1 << i));
			gpio <= 8'(1 << i);
			idle(8);
			#1 check({7'h00, wake_line}, 8'h00);
			idle(1);
			gpio <= ~8'(1 << i);
			idle(8);
			#1 check({7'h00, wake_line}, 8'h01);
			idle(1);
		end
		gpio <= 8'h80;
		wr(WSL_OFS_CTRL, 8'h00);
		idle(6);
		#1 check({7'h00, wake_line}, 8'h01);
		rc(WSL_OFS_WAKE_EN5, 8'h80);
		$display("test wake gating done");
		idle(1);
		rst_in <= 1'b1;
		idle(2);
		rst_in <= 1'b0;
		rc(WSL_OFS_WAKE_EN5, 8'h80);
		rc(WSL_OFS_STS1, 8'h02);
		idle(1);
		periph <= '0;
		rst_sb <= 1'b1;
		idle(2);
		rst_sb <= 1'b0;
		rc(WSL_OFS_WAKE_EN5, 8'h00);
		rc(WSL_OFS_STS2, 8'h00);
		$display("test resets done");
		wr(WSL_OFS_SMI_EN1, 8'h08);
		wr(WSL_OFS_IRQ_MASK, 8'h02);
		rd(WSL_OFS_IRQ_STAT, rd_v);
		idle(1);
		periph <= 7'h10;
		idle(6);
		#1 check({6'h00, smi_seen, irq}, 8'h03);
		rc(WSL_OFS_IRQ_STAT, 8'h02);
		idle(1);
		#1 check({6'h00, smi_seen, irq}, 8'h02);
		wr(WSL_OFS_SMI_EN1, 8'h00);
		idle(4);
		#1 check({6'h00, smi_seen, irq}, 8'h00);
		$display("test smi and interrupt done");
		final_report;
	end
endmodule // test_wake_and_smi_status_logic
`default_nettype wire
